// ==== epl_loader.sv ====
// Purpose: Loads per-port switch configuration from a serial configuration memory.
// Assumes: Memory read port answers each held request with one valid pulse.
// Notes: APB reads of port registers wait until loading has finished.
//
// Our own choices: register access over APB and the register offsets.
module epl_loader
    import epl_pkg::*;
(
    input wire logic clk_i, // Core clock, 50 MHz.
    input wire logic rstn_i, // Asynchronous reset, active low.
    input wire logic mem_present_i, // A valid configuration memory is fitted.
    output logic mem_rd_o, // Read request, held until mem_valid_i.
    output logic [7:0] mem_addr_o, // Byte address of the requested word.
    input wire logic mem_valid_i, // Read data valid, one-cycle pulse.
    input wire logic [15:0] mem_rdata_i, // Word read from memory.
    input wire logic psel_i, // APB select.
    input wire logic penable_i, // APB access phase.
    input wire logic pwrite_i, // APB write.
    input wire logic [12:0] paddr_i, // APB byte address.
    input wire logic [31:0] pwdata_i, // APB write data.
    output logic [31:0] prdata_o, // APB read data.
    output logic pready_o, // APB ready.
    output logic pslverr_o, // APB error on unmapped address.
    output logic cfg_ready_o // Loading finished, accesses served.
);
    import epl_pkg::*;

    epl_state_e state_reg;
    epl_state_e state_next;
    logic [3:0] idx_reg;
    logic [3:0] idx_next;
    logic rd_reg;
    logic rd_next;
    logic [7:0] addr_reg;
    logic [7:0] addr_next;
    logic nomem_reg;
    logic nomem_next;
    logic [NPORT-1:0] gen_we;
    logic [NPORT-1:0] bud_we;
    logic [31:0] port_rdata [NPORT];
    logic [NPORT-1:0] port_hit;
    logic [2:0] sel_port;
    logic start_req;
    logic [7:0] word_addr;
    // The ready flag is kept in its own flip-flop so that the output is glitch free.
    // It is loaded from the state that the sequencer is about to enter, which
    // keeps it in step with the state register rather than one cycle late.
    logic cfg_ready_reg;
    logic cfg_ready_next;

    // Word address for a sequence index: five general words, then six budgets.
    function automatic logic [7:0] idx_to_addr(input logic [3:0] idx);
        logic [7:0] a;
        if (idx < 4'(GEN_WORDS))
        begin
            a = MEM_GEN_BASE + {3'b000, idx, 1'b0};
        end
        else
        begin
            a = MEM_BUD_BASE + {3'b000, idx - 4'(GEN_WORDS), 1'b0};
        end
        return a;
    endfunction

    // The address follows the index that the sequencer is moving to, so a new
    // request stands on the bus in the same cycle as the index that names it.
    // This costs an adder behind the next-state logic but saves a wait cycle
    // per word, which matters because all eleven words are fetched in a row.
    assign word_addr = idx_to_addr(idx_next);

    // Loader sequencing; a software restart reruns the whole load.
    always_comb
    begin
        state_next = state_reg;
        idx_next = idx_reg;
        rd_next = rd_reg;
        addr_next = addr_reg;
        nomem_next = nomem_reg;
        case (state_reg)
            ST_IDLE:
            begin
                state_next = ST_CHECK;
            end
            ST_CHECK:
            begin
                idx_next = 4'h0;
                if (mem_present_i)
                begin
                    nomem_next = 1'b0;
                    rd_next = 1'b1;
                    addr_next = word_addr;
                    state_next = ST_FETCH;
                end
                else
                begin
                    nomem_next = 1'b1;
                    state_next = ST_DONE;
                end
            end
            ST_FETCH:
            begin
                if (mem_valid_i)
                begin
                    if (idx_reg == LAST_IDX)
                    begin
                        rd_next = 1'b0;
                        state_next = ST_DONE;
                    end
                    else
                    begin
                        idx_next = idx_reg + 4'h1;
                        addr_next = word_addr;
                    end
                end
            end
            ST_DONE:
            begin
                if (start_req)
                begin
                    state_next = ST_CHECK;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
                rd_next = 1'b0;
            end
        endcase
        cfg_ready_next = (state_next == ST_DONE);
    end

    // Sequencer registers. Reset returns to idle, so every reset with memory fitted reloads the words.
    // A reset in the middle of a load simply abandons the words fetched so far;
    // the port banks were cleared by the same reset, so nothing stale survives.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg <= ST_IDLE;
            idx_reg <= 4'h0;
            rd_reg <= 1'b0;
            addr_reg <= 8'h00;
            nomem_reg <= 1'b0;
            cfg_ready_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            rd_reg <= rd_next;
            addr_reg <= addr_next;
            nomem_reg <= nomem_next;
            cfg_ready_reg <= cfg_ready_next;
        end
    end

    // Route each arriving word to its port; general words skip port 0.
    always_comb
    begin
        gen_we = '0;
        bud_we = '0;
        if (state_reg == ST_FETCH && mem_valid_i)
        begin
            if (idx_reg < 4'(GEN_WORDS))
            begin
                gen_we[idx_reg[2:0] + 3'h1] = 1'b1;
            end
            else
            begin
                bud_we[3'(idx_reg - 4'(GEN_WORDS))] = 1'b1;
            end
        end
    end

    // One register bank per port.
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        epl_port_regs u_port (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .gen_we_i(gen_we[p]),
            .bud_we_i(bud_we[p]),
            .word_i(mem_rdata_i),
            .rd_off_i(paddr_i[9:0]),
            .rdata_o(port_rdata[p]),
            .hit_o(port_hit[p])
        );
    end

    // APB slave: one wait state, and held off entirely while loading.
    logic ready_reg;
    logic ready_next;
    logic err_reg;
    logic err_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic busy;
    logic ctrl_hit;
    logic stat_hit;
    logic port_ok;

    // Address decode for the register window.
    // Each port owns a 1 KiB window; the two loader words sit in the unused
    // eighth window so that they can never alias a port register.
    // Only whole aligned words are accepted; a byte address inside a word
    // is refused rather than rounded down, so software errors show up early.
    assign busy = (state_reg != ST_DONE);
    assign sel_port = paddr_i[12:10];
    assign ctrl_hit = (paddr_i == CTRL_ADDR);
    assign stat_hit = (paddr_i == STAT_ADDR);
    assign port_ok = (sel_port < 3'(NPORT)) && (paddr_i[1:0] == 2'b00);
    assign start_req = psel_i && penable_i && ready_reg && pwrite_i && ctrl_hit
        && pwdata_i[CTRL_START];

    always_comb
    begin
        ready_next = 1'b0;
        err_next = 1'b0;
        rdata_next = rdata_reg;
        // Register reads wait for the load so software never sees stale defaults.
        if (psel_i && penable_i && !ready_reg && !busy)
        begin
            ready_next = 1'b1;
            rdata_next = 32'h0000_0000;
            if (stat_hit)
            begin
                rdata_next[STAT_BUSY] = busy;
                rdata_next[STAT_DONE] = !busy;
                rdata_next[STAT_NOMEM] = nomem_reg;
            end
            else if (ctrl_hit)
            begin
                rdata_next = 32'h0000_0000;
            end
            else if (port_ok && port_hit[sel_port])
            begin
                if (!pwrite_i)
                begin
                    rdata_next = port_rdata[sel_port];
                end
            end
            else
            begin
                err_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ready_reg <= ready_next;
            err_reg <= err_next;
            rdata_reg <= rdata_next;
        end
    end

    // Every output is a plain flip-flop copy.
    // Downstream logic may therefore sample them without further retiming.
    // The memory request and address stay unchanged until a word is taken.
    assign mem_rd_o = rd_reg;
    assign mem_addr_o = addr_reg;
    assign prdata_o = rdata_reg;
    assign pready_o = ready_reg;
    assign pslverr_o = err_reg;
    assign cfg_ready_o = cfg_ready_reg;

endmodule

// ==== epl_pkg.sv ====
// Purpose: Shared constants for the configuration-memory port loader.
// Assumes: Configuration memory delivers 16-bit words at even byte addresses.
// Notes: Config offsets are byte offsets inside one port's configuration space.
package epl_pkg;

    localparam int unsigned NPORT = 6;
    localparam int unsigned GEN_WORDS = 5;
    localparam int unsigned TOTAL_WORDS = 11;
    localparam logic [3:0] LAST_IDX = 4'hA;

    // Configuration memory word addresses.
    localparam logic [7:0] MEM_GEN_BASE = 8'h62;
    localparam logic [7:0] MEM_BUD_BASE = 8'h70;

    // Bit layout of a per-port general word.
    localparam int unsigned W_SLOT = 0;
    localparam int unsigned W_CLK = 1;
    localparam int unsigned W_DSI = 2;
    localparam int unsigned W_LPC = 3;
    localparam int unsigned W_PNUM_LO = 4;
    localparam int unsigned W_PNUM_HI = 6;
    localparam int unsigned W_MAP_LO = 9;
    localparam int unsigned W_MAP_HI = 15;

    // Bit layout of a power-budgeting word.
    localparam int unsigned B_BASE_HI = 7;
    localparam int unsigned B_SCALE_LO = 8;
    localparam int unsigned B_SCALE_HI = 9;
    localparam int unsigned B_PMST_LO = 10;
    localparam int unsigned B_PMST_HI = 11;
    localparam int unsigned B_SYS = 15;

    // Field positions in the configuration registers.
    localparam int unsigned C_SLOT_BIT = 24;
    localparam int unsigned C_CLK_BIT = 28;
    localparam int unsigned C_DSI_BIT = 21;
    localparam int unsigned C_LPC_BIT = 4;
    localparam int unsigned C_PNUM_LO = 24;
    localparam int unsigned C_MAP_LO = 1;
    localparam int unsigned C_SCALE_LO = 8;
    localparam int unsigned C_PMST_LO = 13;
    localparam int unsigned C_SYS_BIT = 0;

    // Configuration register offsets inside a port's space.
    localparam logic [9:0] OFF_SLOT = 10'h0C0;
    localparam logic [9:0] OFF_CLK = 10'h0D0;
    localparam logic [9:0] OFF_DSI = 10'h040;
    localparam logic [9:0] OFF_LPC = 10'h144;
    localparam logic [9:0] OFF_PNUM = 10'h0CC;
    localparam logic [9:0] OFF_MAP = 10'h154;
    localparam logic [9:0] OFF_BDATA = 10'h214;
    localparam logic [9:0] OFF_BCAP = 10'h218;

    // Reset values of the stored words, giving all-default register bits.
    localparam logic [15:0] RST_GEN_WORD = 16'h0000;
    localparam logic [15:0] RST_BUD_WORD = 16'h0000;

    // Loader control and status registers on APB.
    localparam logic [12:0] CTRL_ADDR = 13'h1C00;
    localparam logic [12:0] STAT_ADDR = 13'h1C04;
    localparam int unsigned CTRL_START = 0;
    localparam int unsigned STAT_BUSY = 0;
    localparam int unsigned STAT_DONE = 1;
    localparam int unsigned STAT_NOMEM = 2;

    typedef enum logic [3:0]
    {
        ST_IDLE = 4'b0001,
        ST_CHECK = 4'b0010,
        ST_FETCH = 4'b0100,
        ST_DONE = 4'b1000
    } epl_state_e;

endpackage

// ==== epl_port_regs.sv ====
// Purpose: Holds one port's loaded words and presents its configuration fields.
// Assumes: Write strobes are one-cycle pulses from the loader.
// Notes: Only the raw words are stored; fields are placed on the read path.
module epl_port_regs
    import epl_pkg::*;
(
    input wire logic clk_i, // Core clock.
    input wire logic rstn_i, // Asynchronous reset, active low.
    input wire logic gen_we_i, // Store a general word.
    input wire logic bud_we_i, // Store a power-budgeting word.
    input wire logic [15:0] word_i, // Word fetched from memory.
    input wire logic [9:0] rd_off_i, // Config offset being read.
    output logic [31:0] rdata_o, // Field image at rd_off_i.
    output logic hit_o // Offset holds a loaded register.
);
    logic [15:0] gen_reg;
    logic [15:0] gen_next;
    logic [15:0] bud_reg;
    logic [15:0] bud_next;

    // Words change only when the loader strobes them.
    always_comb
    begin
        gen_next = gen_we_i ? word_i : gen_reg;
        bud_next = bud_we_i ? word_i : bud_reg;
    end

    // Reset leaves every field at its default value.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            gen_reg <= RST_GEN_WORD;
            bud_reg <= RST_BUD_WORD;
        end
        else
        begin
            gen_reg <= gen_next;
            bud_reg <= bud_next;
        end
    end

    // Scatter the stored word bits into their register positions.
    always_comb
    begin
        rdata_o = 32'h0000_0000;
        hit_o = 1'b1;
        case (rd_off_i)
            OFF_SLOT: rdata_o[C_SLOT_BIT] = gen_reg[W_SLOT];
            OFF_CLK: rdata_o[C_CLK_BIT] = gen_reg[W_CLK];
            OFF_DSI: rdata_o[C_DSI_BIT] = gen_reg[W_DSI];
            OFF_LPC: rdata_o[C_LPC_BIT] = gen_reg[W_LPC];
            OFF_PNUM: rdata_o[C_PNUM_LO +: 3] = gen_reg[W_PNUM_HI:W_PNUM_LO];
            OFF_MAP: rdata_o[C_MAP_LO +: 7] = gen_reg[W_MAP_HI:W_MAP_LO];
            OFF_BDATA:
            begin
                rdata_o[B_BASE_HI:0] = bud_reg[B_BASE_HI:0];
                rdata_o[C_SCALE_LO +: 2] = bud_reg[B_SCALE_HI:B_SCALE_LO];
                rdata_o[C_PMST_LO +: 2] = bud_reg[B_PMST_HI:B_PMST_LO];
            end
            OFF_BCAP: rdata_o[C_SYS_BIT] = bud_reg[B_SYS];
            default: hit_o = 1'b0;
        endcase
    end

endmodule

// ==== epl_loader_asserts.sv ====
// Purpose: Concurrent checks on the loader's memory and APB ports.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Field contents are judged by the bench; these checks watch sequencing.
module epl_loader_asserts
(
    input wire logic clk_i, // Core clock.
    input wire logic rstn_i, // Reset, active low.
    input wire logic mem_present_i, // Memory fitted.
    input wire logic mem_rd_o, // Read request.
    input wire logic [7:0] mem_addr_o, // Word address.
    input wire logic mem_valid_i, // Word valid.
    input wire logic [15:0] mem_rdata_i, // Word data.
    input wire logic psel_i, // APB select.
    input wire logic penable_i, // APB enable.
    input wire logic pwrite_i, // APB write.
    input wire logic [12:0] paddr_i, // APB address.
    input wire logic [31:0] pwdata_i, // APB write data.
    input wire logic [31:0] prdata_o, // APB read data.
    input wire logic pready_o, // APB ready.
    input wire logic pslverr_o, // APB error.
    input wire logic cfg_ready_o // Loading finished.
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // A request keeps its address until the word is taken.
    property p_rd_hold;
        mem_rd_o && !mem_valid_i |=> mem_rd_o && $stable(mem_addr_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read request moved");
    property p_first;
        $rose(mem_rd_o) |-> mem_addr_o == 8'h62;
    endproperty
    a_first: assert property (p_first) else $error("load did not start at 62h");
    // Within a group the address steps by one word.
    property p_step;
        mem_rd_o && mem_valid_i && mem_addr_o != 8'h6A && mem_addr_o != 8'h7A
            |=> mem_addr_o == $past(mem_addr_o) + 8'h02;
    endproperty
    a_step: assert property (p_step) else $error("address did not step by two");
    property p_gap;
        mem_rd_o && mem_valid_i && mem_addr_o == 8'h6A |=> mem_rd_o && mem_addr_o == 8'h70;
    endproperty
    a_gap: assert property (p_gap) else $error("budget words did not follow");
    property p_last;
        mem_rd_o && mem_valid_i && mem_addr_o == 8'h7A |=> !mem_rd_o ##[0:1] cfg_ready_o;
    endproperty
    a_last: assert property (p_last) else $error("load did not end after 7Ah");
    property p_idle;
        cfg_ready_o |-> !mem_rd_o;
    endproperty
    a_idle: assert property (p_idle) else $error("fetch while ready");
    // Accesses must not complete while the load is still running.
    property p_stall;
        !cfg_ready_o && !$past(cfg_ready_o) |-> !pready_o;
    endproperty
    a_stall: assert property (p_stall) else $error("access served during load");
    property p_wait1;
        psel_i && $rose(penable_i) && cfg_ready_o |=> pready_o;
    endproperty
    a_wait1: assert property (p_wait1) else $error("ready not one cycle late");

    c_last: cover property (mem_rd_o && mem_valid_i && mem_addr_o == 8'h7A);
    c_restart: cover property ($fell(cfg_ready_o));
    c_err: cover property (pready_o && pslverr_o);
endmodule

bind epl_loader epl_loader_asserts epl_loader_asserts_inst (.clk_i, .rstn_i, .mem_present_i,
    .mem_rd_o, .mem_addr_o, .mem_valid_i, .mem_rdata_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cfg_ready_o);

// ==== epl_mem_model.sv ====
// Purpose: Behavioural configuration memory answering held read requests.
// Assumes: The word image is a fixed function of the address and a key.
// Notes: Answers after a variable wait, back to back when the wait is zero.
module epl_mem_model
(
    input wire logic clk_i, // Core clock.
    input wire logic rstn_i, // Reset, active low.
    input wire logic mem_rd_i, // Read request.
    input wire logic [7:0] mem_addr_i, // Word address.
    input wire logic [15:0] key_i, // Image selector.
    input wire logic [1:0] dly_i, // Wait before answering.
    output logic mem_valid_o, // Word valid pulse.
    output logic [15:0] mem_rdata_o // Word data.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_reg;
    logic vld_reg;
    logic [15:0] word;

    // Outside a valid cycle the lines show the inverse, so stale data never matches.
    assign word = {mem_addr_i, ~mem_addr_i} ^ key_i;
    assign mem_rdata_o = vld_reg ? word : ~word;
    assign mem_valid_o = vld_reg;

    // No answer is given once the last word has been taken.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_reg <= 2'h0;
            vld_reg <= 1'b0;
        end
        else if (mem_rd_i && cnt_reg >= dly_i && !(vld_reg && mem_addr_i == 8'h7A))
        begin
            cnt_reg <= 2'h0;
            vld_reg <= 1'b1;
        end
        else
        begin
            cnt_reg <= mem_rd_i ? cnt_reg + 2'h1 : 2'h0;
            vld_reg <= 1'b0;
        end
    end
endmodule

// ==== tb_eeprom_port_config_loader.sv ====
// Purpose: Self-checking bench for the configuration loader.
// Assumes: Memory image words are {addr, ~addr} xor a key.
// Notes: Covers load, restart, refused accesses and a reset without memory.
module tb_eeprom_port_config_loader;
    timeunit 1ns;
    timeprecision 1ps;
    import epl_pkg::*;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic mem_present_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [12:0] paddr_i = 13'h0000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [15:0] key = 16'h0000;
    logic [1:0] dly = 2'h0;
    logic mem_rd, mem_valid, pready, pslverr, cfg_ready, err;
    logic [7:0] mem_addr;
    logic [15:0] mem_rdata;
    logic [31:0] prdata, rd;
    int seed = 32'h6140;
    int num_errors = 0;
    int compares = 0;
    bit pres = 1'b1;
    logic [9:0] offs [8] = '{OFF_SLOT, OFF_CLK, OFF_DSI, OFF_LPC, OFF_PNUM, OFF_MAP,
        OFF_BDATA, OFF_BCAP};
    logic [12:0] bad [4] = '{13'h18C0, 13'h0044, 13'h00C1, 13'h1C08};

    epl_loader epl_loader_inst (.clk_i(clk_i), .rstn_i(rstn_i), .mem_present_i(mem_present_i),
        .mem_rd_o(mem_rd), .mem_addr_o(mem_addr), .mem_valid_i(mem_valid),
        .mem_rdata_i(mem_rdata), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .cfg_ready_o(cfg_ready));
    epl_mem_model epl_mem_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .mem_rd_i(mem_rd),
        .mem_addr_i(mem_addr), .key_i(key), .dly_i(dly), .mem_valid_o(mem_valid),
        .mem_rdata_o(mem_rdata));

    // Clock and a random answer delay for the memory.
    initial forever #10 clk_i = ~clk_i;
    always @(posedge clk_i) dly <= 2'($random(seed));

    task automatic test_done();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 300);
        if (n >= 300)
        begin
            num_errors++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (cfg_ready !== 1'b1 && n < 500)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 500)
        begin
            num_errors++;
            test_done();
        end
    endtask

    // Expected field image of offset table entry i of port p.
    function automatic logic [31:0] expv(int p, int i);
        logic [7:0] ga;
        logic [7:0] ba;
        logic [15:0] g;
        logic [15:0] b;
        ga = 8'h60 + 8'(2 * p);
        ba = 8'h70 + 8'(2 * p);
        g = (pres && p > 0) ? {ga, ~ga} ^ key : 16'h0000;
        b = pres ? {ba, ~ba} ^ key : 16'h0000;
        case (i)
            0: return 32'(g[0]) << 24;
            1: return 32'(g[1]) << 28;
            2: return 32'(g[2]) << 21;
            3: return 32'(g[3]) << 4;
            4: return 32'(g[6:4]) << 24;
            5: return 32'(g[15:9]) << 1;
            6: return {17'h0_0000, b[11:10], 3'h0, b[9:0]};
            default: return 32'(b[15]);
        endcase
    endfunction

    task automatic check_all();
        for (int p = 0; p < 6; p++)
            for (int i = 0; i < 8; i++)
            begin
                apb(1'b0, 13'(p * 13'h400) + 13'(offs[i]), 32'h0000_0000);
                if (i < 6) `CHK(rd, expv(p, i))
                else `CHK(rd, expv(p, i))
            end
    endtask

    // Main sequence: load, refusals, restart under load, then a reset without memory.
    initial
    begin
        key = 16'($random(seed));
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        wait_ready();
        check_all();
        foreach (bad[k])
        begin
            apb(1'b0, bad[k], 32'h0000_0000);
            `CHK({err, rd}, 33'h1_0000_0000)
        end
        apb(1'b1, 13'h14C0, 32'hFFFF_FFFF);
        `CHK(err, 1'b0)
        apb(1'b0, 13'h14C0, 32'h0000_0000);
        `CHK(rd, expv(5, 0))
        apb(1'b0, STAT_ADDR, 32'h0000_0000);
        `CHK(rd[2:0], 3'b010)
        key <= ~key;
        apb(1'b1, CTRL_ADDR, 32'h0000_0001);
        apb(1'b0, 13'h1400 + 13'(OFF_MAP), 32'h0000_0000);
        `CHK(rd, expv(5, 5))
        check_all();
        apb(1'b1, CTRL_ADDR, 32'h0000_0001);
        rstn_i <= 1'b0;
        mem_present_i <= 1'b0;
        pres = 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        wait_ready();
        check_all();
        apb(1'b0, STAT_ADDR, 32'h0000_0000);
        `CHK(rd[2:0], 3'b110)
        test_done();
    end
endmodule
